// file: scem_marker.sv
`timescale 1ns/1ns
`include "scem_defines.svh"

module scem_marker
#(
	parameter int unsigned BTL_PULSE_CYC = `SCEM_BTL_PULSE_CYC,
	parameter int unsigned BTL_GAP_CYC   = `SCEM_BTL_GAP_CYC
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        tick_1s,
	input  wire logic        pump_count,
	input  wire logic        no_liquid,
	input  wire logic        bottle_full,
	output logic             pump_rev,
	output logic             pump_fwd,
	output logic             event_mark,
	output logic             bottle_pulse,
	output logic             irq
);
	// ======================================================================
	// Declarations.
	scem_train_if tr ();
	scem_pkg::scem_state_e state_r;
	logic        ap_valid_r;
	logic        ap_write_r;
	logic [7:0]  ap_addr_r;
	logic        ap_word_r;
	logic        wr_en;
	logic [12:0] ctrl_r;
	logic [13:0] pre_r;
	logic [13:0] post_r;
	logic [13:0] line_r;
	logic [13:0] fwd_r;
	logic [7:0]  bottle_r;
	logic [3:0]  irq_stat_r;
	logic [3:0]  irq_mask_r;
	logic [3:0]  irq_ev;
	logic [3:0]  irq_clr;
	logic        cmd_start;
	logic        cmd_stop;
	logic        detect_act;
	logic [13:0] cnt_r;
	logic [13:0] target;
	logic        cnt_done;
	logic        err_r;
	logic        enter_pre;
	logic        pre_done;
	logic        fwd_ok;
	logic        ev_full;
	logic        to_idle;
	logic        every_l;
	scem_pkg::scem_opt_e opt_l;
	logic        detect_l;
	logic        repeat_l;
	logic [13:0] pre_len_l;
	logic [13:0] post_len_l;
	logic [13:0] fwd_len_l;
	logic [7:0]  bottle_l;
	logic        every_sel;
	scem_pkg::scem_opt_e opt_sel;
	logic        mark_start;
	logic        mark_tmr_r;
	logic [1:0]  sec_r;

	// Holds a purge length inside its programmable range.
	function automatic logic [13:0] clamp_purge(input logic [17:0] v);
		logic [17:0] c;
		c = v;
		if (v < `SCEM_PURGE_MIN)
			c = `SCEM_PURGE_MIN;
		else if (v > `SCEM_PURGE_MAX)
			c = `SCEM_PURGE_MAX;
		return c[13:0];
	endfunction

	// ======================================================================
	// AHB-Lite slave with one wait state per transfer.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r  <= 8'h00;
			ap_word_r  <= 1'b0;
			hreadyout  <= 1'b1;
		end
		else if (hsel && hready && htrans[1])
		begin
			ap_valid_r <= 1'b1;
			ap_write_r <= hwrite;
			ap_addr_r  <= haddr[7:0];
			ap_word_r  <= hsize == 3'h2;
			hreadyout  <= 1'b0;
		end
		else
		begin
			ap_valid_r <= 1'b0;
			hreadyout  <= 1'b1;
		end
	end

	// Writes of any size but a whole word are ignored.
	assign wr_en     = ap_valid_r && ap_write_r && ap_word_r;
	assign cmd_start = wr_en && ap_addr_r == `SCEM_OFF_CMD &&
		hwdata[`SCEM_CMD_START];
	assign cmd_stop  = wr_en && ap_addr_r == `SCEM_OFF_CMD &&
		hwdata[`SCEM_CMD_STOP];
	assign irq_clr   = (wr_en && ap_addr_r == `SCEM_OFF_IRQ_STAT) ?
		hwdata[3:0] : 4'h0;

	// Software-written configuration registers.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r     <= `SCEM_CTRL_RESET;
			pre_r      <= `SCEM_PRE_RESET;
			post_r     <= `SCEM_POST_RESET;
			line_r     <= `SCEM_LINE_RESET;
			fwd_r      <= `SCEM_FWD_RESET;
			bottle_r   <= `SCEM_BOTTLE_RESET;
			irq_mask_r <= 4'h0;
		end
		else if (wr_en)
		begin
			unique case (ap_addr_r)
				`SCEM_OFF_CTRL:     ctrl_r     <= hwdata[12:0];
				`SCEM_OFF_PRE:      pre_r      <= hwdata[13:0];
				`SCEM_OFF_POST:     post_r     <= hwdata[13:0];
				`SCEM_OFF_LINE:     line_r     <= hwdata[13:0];
				`SCEM_OFF_FWD:      fwd_r      <= hwdata[13:0];
				`SCEM_OFF_BOTTLE:   bottle_r   <= hwdata[7:0];
				`SCEM_OFF_IRQ_MASK: irq_mask_r <= hwdata[3:0];
				default:            ;
			endcase
		end
	end

	// Read data; unmapped offsets read as zero.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (ap_valid_r && !ap_write_r)
		begin
			unique case (ap_addr_r)
				`SCEM_OFF_CTRL:     hrdata <= {19'h0, ctrl_r};
				`SCEM_OFF_PRE:      hrdata <= {18'h0, pre_r};
				`SCEM_OFF_POST:     hrdata <= {18'h0, post_r};
				`SCEM_OFF_LINE:     hrdata <= {18'h0, line_r};
				`SCEM_OFF_FWD:      hrdata <= {18'h0, fwd_r};
				`SCEM_OFF_BOTTLE:   hrdata <= {24'h0, bottle_r};
				`SCEM_OFF_STATUS:   hrdata <= {26'h0, tr.busy, event_mark,
					detect_act, err_r, state_r};
				`SCEM_OFF_IRQ_STAT: hrdata <= {28'h0, irq_stat_r};
				`SCEM_OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask_r};
				default:            hrdata <= 32'h0;
			endcase
		end
	end

	// The response is always OKAY.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// ======================================================================
	// Sequencer of one sample cycle.
	assign detect_act = ctrl_r[`SCEM_CTRL_COMPOS] &&
		!ctrl_r[`SCEM_CTRL_STD] &&
		ctrl_r[`SCEM_CTRL_FULL_LO + ctrl_r[`SCEM_CTRL_PROG_HI:
		`SCEM_CTRL_PROG_LO]];

	// Target count of the running phase, counted in pump pulses.
	always_comb
	begin
		unique case (state_r)
			scem_pkg::SCEM_PRE:  target = pre_len_l;
			scem_pkg::SCEM_FWD:  target = fwd_len_l;
			scem_pkg::SCEM_POST: target = post_len_l;
			scem_pkg::SCEM_IDLE: target = 14'h0;
		endcase
	end

	assign cnt_done  = cnt_r == target;
	assign pre_done  = state_r == scem_pkg::SCEM_PRE && cnt_done && !cmd_stop;
	assign fwd_ok    = state_r == scem_pkg::SCEM_FWD && cnt_done &&
		!no_liquid && !cmd_stop;
	assign ev_full   = state_r == scem_pkg::SCEM_POST && detect_l &&
		bottle_full && !cmd_stop;
	assign enter_pre = (state_r == scem_pkg::SCEM_IDLE && cmd_start) ||
		(state_r == scem_pkg::SCEM_POST && cnt_done && repeat_l &&
		!ev_full && !cmd_stop);
	assign to_idle   = state_r != scem_pkg::SCEM_IDLE && (cmd_stop ||
		ev_full || (state_r == scem_pkg::SCEM_POST && cnt_done &&
		!repeat_l));

	// Phase changes; a full container outranks repeat_forever.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= scem_pkg::SCEM_IDLE;
			cnt_r   <= 14'h0;
			err_r   <= 1'b0;
		end
		else if (to_idle)
		begin
			state_r <= scem_pkg::SCEM_IDLE;
			cnt_r   <= 14'h0;
		end
		else if (enter_pre)
		begin
			state_r <= scem_pkg::SCEM_PRE;
			cnt_r   <= 14'h0;
			err_r   <= 1'b0;
		end
		else if (pre_done)
		begin
			state_r <= scem_pkg::SCEM_FWD;
			cnt_r   <= 14'h0;
		end
		else if (state_r == scem_pkg::SCEM_FWD && (cnt_done || no_liquid))
		begin
			state_r <= scem_pkg::SCEM_POST;
			cnt_r   <= 14'h0;
			err_r   <= no_liquid;
		end
		else if (pump_count && state_r != scem_pkg::SCEM_IDLE)
			cnt_r <= cnt_r + 14'h1;
	end

	// Configuration is frozen at the start of every cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			every_l    <= 1'b0;
			opt_l      <= scem_pkg::SCEM_OPT_PRE_START;
			detect_l   <= 1'b0;
			repeat_l   <= 1'b0;
			pre_len_l  <= 14'h0;
			post_len_l <= 14'h0;
			fwd_len_l  <= 14'h0;
			bottle_l   <= 8'h00;
		end
		else if (enter_pre)
		begin
			every_l    <= every_sel;
			opt_l      <= opt_sel;
			detect_l   <= detect_act;
			repeat_l   <= ctrl_r[`SCEM_CTRL_REPEAT];
			pre_len_l  <= clamp_purge({4'h0, pre_r});
			post_len_l <= ctrl_r[`SCEM_CTRL_DERIVED] ?
				clamp_purge({4'h0, line_r} * {14'h0, `SCEM_LINE_FACTOR}) :
				clamp_purge({4'h0, post_r});
			fwd_len_l  <= (fwd_r == 14'h0) ? 14'h1 : fwd_r;
			bottle_l   <= bottle_r;
		end
	end

	// Pump drive outputs.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pump_rev <= 1'b0;
			pump_fwd <= 1'b0;
		end
		else
		begin
			pump_rev <= state_r == scem_pkg::SCEM_PRE ||
				state_r == scem_pkg::SCEM_POST;
			pump_fwd <= state_r == scem_pkg::SCEM_FWD;
		end
	end

	// ======================================================================
	// Event mark and bottle-number train.
	assign every_sel = (state_r == scem_pkg::SCEM_IDLE || enter_pre) ?
		ctrl_r[`SCEM_CTRL_EVERY] : every_l;
	assign opt_sel   = (state_r == scem_pkg::SCEM_IDLE || enter_pre) ?
		scem_pkg::scem_opt_e'(ctrl_r[`SCEM_CTRL_OPT_HI:`SCEM_CTRL_OPT_LO]) :
		opt_l;

	// Moment at which the mark and its bottle train begin.
	always_comb
	begin
		mark_start = 1'b0;
		if (!every_sel)
			mark_start = fwd_ok;
		else if (opt_sel == scem_pkg::SCEM_OPT_PRE_START ||
			opt_sel == scem_pkg::SCEM_OPT_WHOLE)
			mark_start = enter_pre;
		else
			mark_start = pre_done;
	end

	// Three-second timer clocked by the one-second tick.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mark_tmr_r <= 1'b0;
			sec_r      <= 2'h0;
		end
		else if (mark_start && (!every_sel ||
			opt_sel == scem_pkg::SCEM_OPT_PRE_START ||
			opt_sel == scem_pkg::SCEM_OPT_FWD_START))
		begin
			mark_tmr_r <= 1'b1;
			sec_r      <= 2'h0;
		end
		else if (mark_tmr_r && tick_1s)
		begin
			mark_tmr_r <= sec_r != `SCEM_MARK_SECONDS - 2'h1;
			sec_r      <= sec_r + 2'h1;
		end
	end

	// Mark output in the form chosen for the cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			event_mark <= 1'b0;
		else if (every_l && opt_l == scem_pkg::SCEM_OPT_WHOLE)
			event_mark <= state_r != scem_pkg::SCEM_IDLE;
		else if (every_l && opt_l == scem_pkg::SCEM_OPT_FWD_ONLY)
			event_mark <= state_r == scem_pkg::SCEM_FWD;
		else
			event_mark <= mark_tmr_r;
	end

	assign tr.start = mark_start;
	// A cycle that starts now sends the bottle number being latched.
	assign tr.count = enter_pre ? bottle_r : bottle_l;

	scem_pulse_train #(.WIDTH_CYC(BTL_PULSE_CYC), .GAP_CYC(BTL_GAP_CYC))
		u_train (.hclk(hclk), .hresetn(hresetn), .tr(tr));

	// Registered copy of the train for the connector pin.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bottle_pulse <= 1'b0;
		else
			bottle_pulse <= tr.pulse;
	end

	// ======================================================================
	// Interrupts: done, no liquid, bottle full, routine ended; set wins.
	assign irq_ev = {to_idle, ev_full,
		state_r == scem_pkg::SCEM_FWD && no_liquid,
		state_r == scem_pkg::SCEM_POST && cnt_done};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_stat_r <= 4'h0;
			irq        <= 1'b0;
		end
		else
		begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			irq        <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ======================================================================
	// Checks.
	chk_full_ends_run: assert property (@(posedge hclk) disable iff (!hresetn)
		ev_full |=> state_r == scem_pkg::SCEM_IDLE)
		else $error("Full container did not end the routine.");
	chk_full_over_repeat: assert property (@(posedge hclk) disable iff (!hresetn)
		ev_full && repeat_l |=> state_r == scem_pkg::SCEM_IDLE ##1
		state_r == scem_pkg::SCEM_IDLE || cmd_start)
		else $error("Repeat survived a full container.");
	chk_std_no_detect: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_r[`SCEM_CTRL_STD] && enter_pre |=> !detect_l)
		else $error("Full detection active in standard mode.");
	chk_err_no_mark: assert property (@(posedge hclk) disable iff (!hresetn)
		!every_l && state_r == scem_pkg::SCEM_FWD && no_liquid |=>
		!mark_tmr_r [*3])
		else $error("Mark sent for a failed sample.");
	chk_pre_mark: assert property (@(posedge hclk) disable iff (!hresetn)
		enter_pre && every_sel && opt_sel == scem_pkg::SCEM_OPT_PRE_START
		|=> mark_tmr_r ##1 event_mark)
		else $error("No mark at pre purge start.");
	chk_fwd_mark: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_done && every_l && opt_l == scem_pkg::SCEM_OPT_FWD_START
		|=> mark_tmr_r)
		else $error("No mark at forward start.");
	chk_three_sec: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(mark_tmr_r) |-> $past(tick_1s) && $past(sec_r) == 2'h2)
		else $error("Mark pulse not three ticks long.");
	chk_whole_mark: assert property (@(posedge hclk) disable iff (!hresetn)
		every_l && opt_l == scem_pkg::SCEM_OPT_WHOLE &&
		state_r != scem_pkg::SCEM_IDLE |=> event_mark)
		else $error("Whole-cycle mark dropped.");
	chk_fwd_only: assert property (@(posedge hclk) disable iff (!hresetn)
		every_l && opt_l == scem_pkg::SCEM_OPT_FWD_ONLY &&
		$stable(opt_l) |=> event_mark == $past(state_r == scem_pkg::SCEM_FWD))
		else $error("Forward-only mark wrong.");
	chk_train_go: assert property (@(posedge hclk) disable iff (!hresetn)
		mark_start && !tr.busy && tr.count != 8'h00 |=> tr.busy ##1 bottle_pulse)
		else $error("Bottle train did not start with the mark.");
	chk_pre_len: assert property (@(posedge hclk) disable iff (!hresetn)
		state_r == scem_pkg::SCEM_PRE ##1 state_r == scem_pkg::SCEM_FWD
		|-> $past(cnt_r) == $past(pre_len_l))
		else $error("Pre purge length wrong.");
	chk_post_range: assert property (@(posedge hclk) disable iff (!hresetn)
		state_r == scem_pkg::SCEM_POST |-> post_len_l >= 14'h000a &&
		post_len_l <= 14'h270f)
		else $error("Post purge length out of range.");

	cov_cycle_done: cover property (@(posedge hclk) disable iff (!hresetn)
		irq_ev[0]);
	cov_full_stop: cover property (@(posedge hclk) disable iff (!hresetn)
		ev_full && repeat_l);
	cov_no_liquid: cover property (@(posedge hclk) disable iff (!hresetn)
		irq_ev[1] && !every_l);
	cov_train: cover property (@(posedge hclk) disable iff (!hresetn)
		$fell(tr.busy));
endmodule

// file: scem_defines.svh
`ifndef SCEM_DEFINES_SVH
`define SCEM_DEFINES_SVH

// ==========================================================================
// Register byte offsets.
`define SCEM_OFF_CTRL       8'h00
`define SCEM_OFF_PRE        8'h04
`define SCEM_OFF_POST       8'h08
`define SCEM_OFF_LINE       8'h0c
`define SCEM_OFF_FWD        8'h10
`define SCEM_OFF_BOTTLE     8'h14
`define SCEM_OFF_CMD        8'h18
`define SCEM_OFF_STATUS     8'h1c
`define SCEM_OFF_IRQ_STAT   8'h20
`define SCEM_OFF_IRQ_MASK   8'h24

// ==========================================================================
// Control and command register field positions.
`define SCEM_CTRL_EVERY     0
`define SCEM_CTRL_OPT_LO    1
`define SCEM_CTRL_OPT_HI    2
`define SCEM_CTRL_STD       3
`define SCEM_CTRL_REPEAT    4
`define SCEM_CTRL_COMPOS    5
`define SCEM_CTRL_DERIVED   6
`define SCEM_CTRL_PROG_LO   7
`define SCEM_CTRL_PROG_HI   8
`define SCEM_CTRL_FULL_LO   9
`define SCEM_CTRL_FULL_HI   12
`define SCEM_CMD_START      0
`define SCEM_CMD_STOP       1

// ==========================================================================
// Reset values.
`define SCEM_CTRL_RESET     13'h0000
`define SCEM_PRE_RESET      14'h00c8
`define SCEM_POST_RESET     14'h00c8
`define SCEM_LINE_RESET     14'h000a
`define SCEM_FWD_RESET      14'h0064
`define SCEM_BOTTLE_RESET   8'h01

// ==========================================================================
// Limits and timing.
`define SCEM_PURGE_MIN      18'h0000a
`define SCEM_PURGE_MAX      18'h0270f
`define SCEM_LINE_FACTOR    4'ha
`define SCEM_MARK_SECONDS   2'h3
`define SCEM_CLK_PERIOD_NS  10
`define SCEM_BTL_PULSE_MS   50
`define SCEM_BTL_GAP_MS     50
`define SCEM_BTL_PULSE_CYC  (`SCEM_BTL_PULSE_MS * 1000000 / `SCEM_CLK_PERIOD_NS)
`define SCEM_BTL_GAP_CYC    (`SCEM_BTL_GAP_MS * 1000000 / `SCEM_CLK_PERIOD_NS)

`endif

// file: scem_pkg.sv
package scem_pkg;

	// Sequencer states of one sample cycle.
	typedef enum logic [1:0]
	{
		SCEM_IDLE = 2'b00,
		SCEM_PRE  = 2'b01,
		SCEM_FWD  = 2'b10,
		SCEM_POST = 2'b11
	} scem_state_e;

	// Pulse forms of the every-initiation mark mode.
	typedef enum logic [1:0]
	{
		SCEM_OPT_PRE_START = 2'b00,
		SCEM_OPT_FWD_START = 2'b01,
		SCEM_OPT_WHOLE     = 2'b10,
		SCEM_OPT_FWD_ONLY  = 2'b11
	} scem_opt_e;

endpackage

// file: scem_train_if.sv
`timescale 1ns/1ns

// Carries a bottle-number pulse request and the generated train.
interface scem_train_if;
	logic       start;
	logic [7:0] count;
	logic       busy;
	logic       pulse;

	modport src (output start, output count, input busy, input pulse);
	modport gen (input start, input count, output busy, output pulse);
endinterface

// file: scem_pulse_train.sv
`timescale 1ns/1ns

// Emits a train of count pulses of fixed width and spacing.
module scem_pulse_train
#(
	parameter int unsigned WIDTH_CYC = 4,
	parameter int unsigned GAP_CYC   = 4
)
(
	input wire logic hclk,
	input wire logic hresetn,
	scem_train_if.gen tr
);
	logic [7:0]  remain_r;
	logic [31:0] timer_r;

	// A start during a running train is ignored so the count stays exact.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			remain_r <= 8'h00;
			timer_r  <= 32'h0;
			tr.busy  <= 1'b0;
			tr.pulse <= 1'b0;
		end
		else if (tr.start && !tr.busy)
		begin
			remain_r <= tr.count;
			timer_r  <= 32'h0;
			tr.busy  <= (tr.count != 8'h00);
			tr.pulse <= (tr.count != 8'h00);
		end
		else if (tr.busy)
		begin
			if (tr.pulse && timer_r == WIDTH_CYC - 32'h1)
			begin
				tr.pulse <= 1'b0;
				timer_r  <= 32'h0;
				remain_r <= remain_r - 8'h01;
				tr.busy  <= (remain_r != 8'h01);
			end
			else if (!tr.pulse && timer_r == GAP_CYC - 32'h1)
			begin
				tr.pulse <= 1'b1;
				timer_r  <= 32'h0;
			end
			else
			begin
				timer_r <= timer_r + 32'h1;
			end
		end
	end

	// A train never outlasts its own pulse count.
	chk_train_ends: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(tr.pulse) |-> tr.busy == (remain_r != 8'h00))
		else $error("Pulse train ran past its count.");
endmodule

// file: scem_logger_model.sv
`timescale 1ns/1ns

// =====
// Logger at the far end of the instrument connector.
module scem_logger_model
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic event_mark,
	input  wire logic bottle_pulse,
	output int        marks,
	output int        pulses,
	output int        width
);
	logic mark_q;
	logic btl_q;

	// Counts mark starts, bottle pulses and the length of the last mark.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mark_q <= 1'b0;
			btl_q <= 1'b0;
			marks <= 0;
			pulses <= 0;
			width <= 0;
		end
		else
		begin
			mark_q <= event_mark;
			btl_q <= bottle_pulse;
			if (event_mark && !mark_q)
			begin
				marks <= marks + 1;
				width <= 1;
			end
			else if (event_mark)
				width <= width + 1;
			if (bottle_pulse && !btl_q)
				pulses <= pulses + 1;
		end
	end
endmodule

// file: test_sample_cycle_event_marker.sv
`timescale 1ns/1ns
`include "scem_defines.svh"

// =====
// Comparison helper.
`define CHECK(nm, ex, gt) \
	begin \
		comparisons++; \
		if ((gt) !== (ex)) \
		begin \
			miscompares++; \
			$display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end

module test_sample_cycle_event_marker;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        tick_1s;
	logic        pump_count;
	logic        no_liquid;
	logic        bottle_full;
	logic        pump_rev;
	logic        pump_fwd;
	logic        event_mark;
	logic        bottle_pulse;
	logic        irq;
	int          marks;
	int          pulses;
	int          width;
	int          tick_cnt;
	int          miscompares;
	int          comparisons;

	assign hready = hreadyout;

	scem_marker #(.BTL_PULSE_CYC(4), .BTL_GAP_CYC(4)) i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .tick_1s(tick_1s), .pump_count(pump_count),
		.no_liquid(no_liquid), .bottle_full(bottle_full),
		.pump_rev(pump_rev), .pump_fwd(pump_fwd), .event_mark(event_mark),
		.bottle_pulse(bottle_pulse), .irq(irq)
	);

	scem_logger_model i_log
	(
		.hclk(hclk), .hresetn(hresetn), .event_mark(event_mark),
		.bottle_pulse(bottle_pulse), .marks(marks), .pulses(pulses),
		.width(width)
	);

	// Clock of 10 ns.
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Pump gives a count every other cycle while running; time base of 40.
	always @(posedge hclk)
	begin
		pump_count <= (pump_rev | pump_fwd) & !pump_count;
		tick_cnt <= (tick_cnt == 39) ? 0 : tick_cnt + 1;
		tick_1s <= (tick_cnt == 39);
	end

	// =====
	// Bus tasks.
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		`CHECK("hresp", 1'b0, hresp)
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, a, 32'h00000000, q);
	endtask

	task automatic run(input logic [31:0] ctrl);
		wr(`SCEM_OFF_CTRL, ctrl);
		wr(`SCEM_OFF_CMD, 32'h00000001);
	endtask

	task automatic wait_quiet();
		logic [31:0] s;
		do rd(`SCEM_OFF_STATUS, s); while ({s[5:4], s[1:0]} !== 4'h0);
	endtask

	// =====
	// Scenarios.
	task automatic t_regs();
		logic [31:0] q;
		rd(`SCEM_OFF_PRE, q);
		`CHECK("pre_reset", 32'h000000c8, q)
		rd(`SCEM_OFF_BOTTLE, q);
		`CHECK("bottle_reset", 32'h00000001, q)
		rd(8'h30, q);
		`CHECK("unmapped", 32'h00000000, q)
		wr(`SCEM_OFF_PRE, 32'h00000005);
		wr(`SCEM_OFF_FWD, 32'h00000004);
		wr(`SCEM_OFF_POST, 32'h0000000a);
		wr(`SCEM_OFF_LINE, 32'h00000002);
		wr(`SCEM_OFF_BOTTLE, 32'h00000003);
	endtask

	task automatic t_complete();
		int m0;
		int p0;
		m0 = marks;
		p0 = pulses;
		run(32'h00000000);
		wait_quiet();
		`CHECK("good_mark", 1, marks - m0)
		`CHECK("good_train", 3, pulses - p0)
		`CHECK("mark_len", 1'b1, width >= 79 && width <= 122)
	endtask

	task automatic t_noliq();
		logic [31:0] q;
		int          m0;
		m0 = marks;
		no_liquid <= 1'b1;
		run(32'h00000000);
		wait_quiet();
		no_liquid <= 1'b0;
		`CHECK("error_mark", 0, marks - m0)
		rd(`SCEM_OFF_IRQ_STAT, q);
		`CHECK("noliq_flag", 1'b1, q[1])
		`CHECK("irq_masked", 1'b0, irq)
		wr(`SCEM_OFF_IRQ_MASK, 32'h00000002);
		repeat (2) @(posedge hclk);
		`CHECK("irq_set", 1'b1, irq)
		wr(`SCEM_OFF_IRQ_STAT, 32'h0000000f);
		repeat (2) @(posedge hclk);
		`CHECK("irq_clear", 1'b0, irq)
		wr(`SCEM_OFF_IRQ_MASK, 32'h00000000);
	endtask

	task automatic t_opts();
		int   m0;
		int   p0;
		int   pre_n;
		int   post_n;
		logic on;
		logic fwd_seen;
		logic mq;
		for (int o = 0; o < 4; o++)
		begin
			m0 = marks;
			p0 = pulses;
			pre_n = 0;
			post_n = 0;
			on = 1'b0;
			fwd_seen = 1'b0;
			mq = 1'b0;
			run(32'h00000041 | (o << 1));
			do
			begin
				@(posedge hclk);
				if (o == 2) `CHECK("whole", pump_rev | pump_fwd, event_mark)
				if (o == 3) `CHECK("fwd_only", pump_fwd, event_mark)
				if (event_mark && !mq && o == 0) `CHECK("pre_go", 1'b1, pump_rev)
				if (event_mark && !mq && o == 1) `CHECK("fwd_go", 1'b1, pump_fwd)
				mq = event_mark;
				fwd_seen |= pump_fwd;
				if (pump_count && pump_rev && fwd_seen)
					post_n++;
				if (pump_count && pump_rev && !fwd_seen)
					pre_n++;
				on |= pump_rev;
			end
			while (!on || pump_rev || pump_fwd);
			wait_quiet();
			`CHECK("one_mark", 1, marks - m0)
			`CHECK("train", 3, pulses - p0)
			`CHECK("pre_len", 1'b1, pre_n >= 10 && pre_n <= 11)
			`CHECK("post_len", 1'b1, post_n >= 20 && post_n <= 21)
		end
	endtask

	task automatic t_detect();
		logic [31:0] q;
		logic [31:0] cfg [3];
		logic        det [3];
		cfg = '{32'h00000930, 32'h00000330, 32'h00000938};
		det = '{1'b1, 1'b0, 1'b0};
		wr(`SCEM_OFF_POST, 32'h00000065);
		for (int i = 0; i < 3; i++)
		begin
			run(cfg[i]);
			rd(`SCEM_OFF_STATUS, q);
			`CHECK("detect_on", det[i], q[3])
			wr(`SCEM_OFF_CMD, 32'h00000002);
			wait_quiet();
		end
		wr(`SCEM_OFF_IRQ_STAT, 32'h0000000f);
		bottle_full <= 1'b1;
		run(cfg[0]);
		wait_quiet();
		bottle_full <= 1'b0;
		rd(`SCEM_OFF_IRQ_STAT, q);
		`CHECK("full_stop", 1'b1, q[2])
	endtask

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence.
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
		tick_1s = 1'b0;
		pump_count = 1'b0;
		tick_cnt = 0;
		no_liquid = 1'b0;
		bottle_full = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_complete();
		t_noliq();
		t_opts();
		t_detect();
		print_verdict();
	end

	// Cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge hclk);
		miscompares++;
		print_verdict();
	end
endmodule
